// File: pwm_pkg.sv
// Purpose: shared constants for the one-shot period timer and pulse modulator block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: two period timers and two modulator channels; each channel picks its timer
//
// Contract
// - one-shot period match zeroes the count and clears the run bit
// - mode field 01000 selects software-started one-shot operation
// - clearing run mid-cycle pauses counting; setting it resumes to completion
// - in one-shot, pulse drive starts in the cycle run is set
// - drive ends at width match and stays off until run is set again
// - clearing run during drive or between width and period match extends drive
// - a new one-shot cycle starts only by setting run after period match cleared it
// - each modulator channel selects its own timer source independently
// - modulator control bit 7 enables the channel, resets to 0
// - modulator control bit 5 is read-only and shows the output level
// - modulator control bit 4 set makes the output active-low
// - modulator control bits 6 and 3..0 ignore writes and read zero
package pwm_pkg;
  localparam int NUM_UNITS = 2;
  localparam int ADDR_W = 6;

  // register byte offsets; pairs are unit 0 at the offset, unit 1 four bytes higher
  localparam logic [ADDR_W-1:0] OFF_TIMER_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_DUTY = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_CMP_CTRL = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_MOD_CTRL = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 6'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h34;

  // period_timer_control fields
  localparam int TC_RUN = 0;
  localparam int TC_PS_LSB = 1;
  localparam int TC_PS_W = 2;
  localparam int TC_MODE_LSB = 3;
  localparam int TC_MODE_W = 5;
  localparam logic [TC_MODE_W-1:0] MODE_ONE_SHOT = 5'h08;
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;

  // compare_module_control fields
  localparam int CC_SRC = 0;
  localparam int CC_FMT = 1;
  localparam logic [1:0] CMP_CTRL_RESET = 2'h0;

  // modulator_control fields
  localparam int MC_EN = 7;
  localparam int MC_OUT = 5;
  localparam int MC_POL = 4;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RWAIT = 4'h4,
    BUS_RDONE = 4'h8
  } bus_state_t;
endpackage

// File: one_shot_timer_pwm.sv
// Purpose: period timers with one-shot mode driving polarity-selectable pulse outputs
// Assumes: single clock, synchronous active-low reset, AHB-Lite single word transfers
// Notes: writes take no wait state, reads take one so read data comes from a flop
`timescale 1ns/1ps
`default_nettype none
module one_shot_timer_pwm #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [pwm_pkg::ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // modulator outputs and interrupt
  output logic [pwm_pkg::NUM_UNITS-1:0] MOD_OUT,
  output logic IRQ
);
  import pwm_pkg::*;

  bus_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [NUM_UNITS-1:0] irq_stat_ff, nxt_irq_stat;
  logic [NUM_UNITS-1:0] irq_mask_ff, nxt_irq_mask;
  logic [NUM_UNITS-1:0] match;
  logic [NUM_UNITS-1:0] out_lvl;
  logic [7:0] tctrl [NUM_UNITS];
  logic [CNT_W-1:0] period [NUM_UNITS];
  logic [CNT_W-1:0] count [NUM_UNITS];
  logic [2*CNT_W-1:0] duty [NUM_UNITS];
  logic [1:0] cctrl [NUM_UNITS];
  logic [7:0] mctrl [NUM_UNITS];
  // look-ahead timer state, so a channel can react in the cycle run is set
  logic [NUM_UNITS-1:0] nxt_run_v;
  logic [NUM_UNITS-1:0] nxt_mid_v;
  logic [NUM_UNITS-1:0] oneshot_v;
  logic [CNT_W-1:0] nxt_count_v [NUM_UNITS];
  logic accept;
  logic wr_now;
  logic unit_sel;

  assign accept = HSEL && HTRANS[1] && HREADY;
  assign wr_now = (state_ff == BUS_WRITE);
  assign unit_sel = addr_ff[2];

  // bus sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    unique case (state_ff)
      BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
        if (accept) begin
          nxt_addr = HADDR;
          nxt_state = HWRITE ? BUS_WRITE : BUS_RWAIT;
        end else begin
          nxt_state = BUS_IDLE;
        end
      end
      BUS_RWAIT: begin
        nxt_state = BUS_RDONE;
      end
    endcase
  end

  // read mux, evaluated in the wait state so writes just before are visible
  always_comb begin
    nxt_rdata = rdata_ff;
    if (state_ff == BUS_RWAIT) begin
      nxt_rdata = 32'h0000_0000;
      if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_TIMER_CTRL) begin
        nxt_rdata = 32'(tctrl[unit_sel]);
      end else if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_PERIOD) begin
        nxt_rdata = 32'(period[unit_sel]);
      end else if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_COUNT) begin
        nxt_rdata = 32'(count[unit_sel]);
      end else if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_DUTY) begin
        nxt_rdata = 32'(duty[unit_sel]);
      end else if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_CMP_CTRL) begin
        nxt_rdata = 32'(cctrl[unit_sel]);
      end else if ({addr_ff[ADDR_W-1:3], 3'h0} == OFF_MOD_CTRL) begin
        nxt_rdata = 32'(mctrl[unit_sel]);
      end else if (addr_ff == OFF_IRQ_STATUS) begin
        nxt_rdata = 32'(irq_stat_ff);
      end else if (addr_ff == OFF_IRQ_MASK) begin
        nxt_rdata = 32'(irq_mask_ff);
      end
    end
  end

  // interrupt status: a period match in the clearing cycle still sets the bit
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_now && addr_ff == OFF_IRQ_STATUS) begin
      nxt_irq_stat = irq_stat_ff & ~HWDATA[NUM_UNITS-1:0];
    end
    if (wr_now && addr_ff == OFF_IRQ_MASK) begin
      nxt_irq_mask = HWDATA[NUM_UNITS-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | match;
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_ff <= BUS_IDLE;
      addr_ff <= '0;
      rdata_ff <= 32'h0000_0000;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign HRDATA = rdata_ff;
  assign HREADYOUT = (state_ff != BUS_RWAIT);
  assign HRESP = 1'b0;
  assign IRQ = |(irq_stat_ff & irq_mask_ff);
  assign MOD_OUT = out_lvl;

  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    logic [7:0] tctrl_ff, nxt_tctrl;
    logic [CNT_W-1:0] period_ff, nxt_period;
    logic [CNT_W-1:0] count_ff, nxt_count;
    logic [2:0] ps_cnt_ff, nxt_ps_cnt;
    logic mid_ff, nxt_mid;
    logic [2*CNT_W-1:0] duty_ff, nxt_duty;
    logic [1:0] cctrl_ff, nxt_cctrl;
    logic en_ff, nxt_en;
    logic pol_ff, nxt_pol;
    logic out_ff, nxt_out;
    logic sel_unit;
    logic run;
    logic one_shot;
    logic tick;
    logic [2:0] ps_lim;
    logic src;
    logic [CNT_W-1:0] width;
    logic active;

    assign sel_unit = wr_now && (unit_sel == 1'(u));
    assign run = tctrl_ff[TC_RUN];
    assign one_shot = (tctrl_ff[TC_MODE_LSB +: TC_MODE_W] == MODE_ONE_SHOT);
    assign ps_lim = 3'((4'h1 << tctrl_ff[TC_PS_LSB +: TC_PS_W]) - 4'h1);
    assign tick = run && (ps_cnt_ff == ps_lim);
    assign match[u] = tick && (count_ff == period_ff);

    // timer: a stopped timer holds its count and prescale phase
    always_comb begin
      nxt_tctrl = tctrl_ff;
      nxt_period = period_ff;
      nxt_count = count_ff;
      nxt_ps_cnt = ps_cnt_ff;
      nxt_mid = mid_ff;
      if (run) begin
        nxt_ps_cnt = tick ? 3'h0 : ps_cnt_ff + 3'h1;
        if (match[u]) begin
          nxt_count = '0;
        end else if (tick) begin
          nxt_count = count_ff + 1'b1;
        end
      end
      if (one_shot && match[u]) begin
        nxt_tctrl[TC_RUN] = 1'b0;
        nxt_mid = 1'b0;
      end else if (run) begin
        nxt_mid = 1'b1;
      end
      if (sel_unit && {addr_ff[ADDR_W-1:3], 3'h0} == OFF_TIMER_CTRL) begin
        // software owns run; a fresh cycle needs run set again after the match
        nxt_tctrl = HWDATA[7:0];
      end
      if (sel_unit && {addr_ff[ADDR_W-1:3], 3'h0} == OFF_PERIOD) begin
        nxt_period = HWDATA[CNT_W-1:0];
      end
    end

    assign tctrl[u] = tctrl_ff;
    assign period[u] = period_ff;
    assign count[u] = count_ff;
    assign nxt_run_v[u] = nxt_tctrl[TC_RUN];
    assign nxt_mid_v[u] = nxt_mid;
    assign nxt_count_v[u] = nxt_count;
    assign oneshot_v[u] = (nxt_tctrl[TC_MODE_LSB +: TC_MODE_W] == MODE_ONE_SHOT);

    // channel: picks its own timer, uses look-ahead so drive starts with run
    assign src = cctrl_ff[CC_SRC];
    assign width = cctrl_ff[CC_FMT] ? duty_ff[2*CNT_W-1:CNT_W] : duty_ff[CNT_W-1:0];

    always_comb begin
      nxt_duty = duty_ff;
      nxt_cctrl = cctrl_ff;
      nxt_en = en_ff;
      nxt_pol = pol_ff;
      if (sel_unit && {addr_ff[ADDR_W-1:3], 3'h0} == OFF_DUTY) begin
        nxt_duty = HWDATA[2*CNT_W-1:0];
      end
      if (sel_unit && {addr_ff[ADDR_W-1:3], 3'h0} == OFF_CMP_CTRL) begin
        nxt_cctrl = HWDATA[1:0];
      end
      if (sel_unit && {addr_ff[ADDR_W-1:3], 3'h0} == OFF_MOD_CTRL) begin
        // output level bit and unused bits are not stored
        nxt_en = HWDATA[MC_EN];
        nxt_pol = HWDATA[MC_POL];
      end
      if (oneshot_v[src]) begin
        // paused mid-cycle keeps the drive on; otherwise on until width match
        active = (nxt_run_v[src] && nxt_count_v[src] < width) ||
                 (!nxt_run_v[src] && nxt_mid_v[src]);
      end else begin
        active = nxt_run_v[src] && (nxt_count_v[src] < width);
      end
      // disabled channel rests low regardless of polarity
      nxt_out = nxt_en && (active ^ nxt_pol);
    end

    assign duty[u] = duty_ff;
    assign cctrl[u] = cctrl_ff;
    assign mctrl[u] = {en_ff, 1'b0, out_ff, pol_ff, 4'h0};
    assign out_lvl[u] = out_ff;

    always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
        tctrl_ff <= TIMER_CTRL_RESET;
        period_ff <= '0;
        count_ff <= '0;
        ps_cnt_ff <= 3'h0;
        mid_ff <= 1'b0;
        duty_ff <= '0;
        cctrl_ff <= CMP_CTRL_RESET;
        en_ff <= 1'b0;
        pol_ff <= 1'b0;
        out_ff <= 1'b0;
      end else begin
        tctrl_ff <= nxt_tctrl;
        period_ff <= nxt_period;
        count_ff <= nxt_count;
        ps_cnt_ff <= nxt_ps_cnt;
        mid_ff <= nxt_mid;
        duty_ff <= nxt_duty;
        cctrl_ff <= nxt_cctrl;
        en_ff <= nxt_en;
        pol_ff <= nxt_pol;
        out_ff <= nxt_out;
      end
    end
  end
endmodule
`default_nettype wire

// File: osp_props.sv
// Purpose: bus timing and modulator control checks
// Assumes: one master, single word transfers
// Notes: shadows enable and polarity from bus writes
`timescale 1ns/1ps
`default_nettype none
module osp_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // bus
  input wire logic HSEL,
  input wire logic [pwm_pkg::ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  // outputs
  input wire logic [pwm_pkg::NUM_UNITS-1:0] MOD_OUT,
  input wire logic IRQ
);
  import pwm_pkg::*;
  logic taken, rdone, mc, wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [ADDR_W-1:0] a_ff, nxt_a;
  logic [1:0][1:0] ctl_ff, nxt_ctl;
  assign taken = HSEL && HTRANS[1] && HREADY;
  assign rdone = rd_ff && HREADY;
  assign mc = a_ff[5:3] == OFF_MOD_CTRL[5:3];
  always_comb begin
    nxt_a = taken ? HADDR : a_ff;
    nxt_wr = taken ? HWRITE : wr_ff && !HREADY;
    nxt_rd = taken ? !HWRITE : rd_ff && !HREADY;
    nxt_ctl = ctl_ff;
    // shadow follows the data phase, as the registers do
    if (wr_ff && HREADY && mc) begin
      nxt_ctl[a_ff[2]] = {HWDATA[MC_EN], HWDATA[MC_POL]};
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      a_ff <= '0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      ctl_ff <= '0;
    end else begin
      a_ff <= nxt_a;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      ctl_ff <= nxt_ctl;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  property p_wr0; taken && HWRITE |=> HREADYOUT; endproperty
  property p_rd1; taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
  property p_rst;
    disable iff (1'b0) !RESETN |=> HREADYOUT && !IRQ && MOD_OUT == '0;
  endproperty
  property p_dis0; !ctl_ff[0][1] && !$past(ctl_ff[0][1]) |-> !MOD_OUT[0]; endproperty
  property p_dis1; !ctl_ff[1][1] && !$past(ctl_ff[1][1]) |-> !MOD_OUT[1]; endproperty
  property p_rsvd; rdone && mc |-> HRDATA[31:8] == '0 && !HRDATA[6] && HRDATA[3:0] == '0;
  endproperty
  property p_rdbk; rdone && mc |-> HRDATA[7] == ctl_ff[a_ff[2]][1]
    && HRDATA[4] == ctl_ff[a_ff[2]][0]; endproperty
  property p_outrd; rdone && mc && $stable(MOD_OUT) |-> HRDATA[5] == MOD_OUT[a_ff[2]];
  endproperty
  a_wr0: assert property (p_wr0) else $error("write waited");
  a_rd1: assert property (p_rd1) else $error("read wait not one cycle");
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
  a_dis0: assert property (p_dis0) else $error("disabled channel 0 drives");
  a_dis1: assert property (p_dis1) else $error("disabled channel 1 drives");
  a_rsvd: assert property (p_rsvd) else $error("unused control bits set");
  a_rdbk: assert property (p_rdbk) else $error("enable or polarity readback");
  a_outrd: assert property (p_outrd) else $error("output level readback");
  c_rd_ctrl: cover property (rdone && mc);
  c_irq: cover property ($rose(IRQ));
  c_pulse: cover property ($rose(MOD_OUT[0]));
endmodule
bind one_shot_timer_pwm osp_props props_i (.CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .MOD_OUT(MOD_OUT), .IRQ(IRQ));
`default_nettype wire

// File: pin_model.sv
// Purpose: output pin behind routing and a tri-state driver
// Assumes: no pull resistor on the pad
// Notes: a released pad shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // clock
  input wire logic clk,
  // routed source and tri-state bit
  input wire logic src,
  input wire logic pin_tristate,
  // pad
  output logic pad
);
  logic last_ff;
  always_ff @(posedge clk) begin
    if (!pin_tristate) begin
      last_ff <= src;
    end
  end
  // floating pad must not look like a held level
  assign pad = pin_tristate ? !last_ff : src;
endmodule
`default_nettype wire

// File: test_one_shot_timer_pwm.sv
// Purpose: self-checking bench for the one-shot timer modulator
// Assumes: reads answer after one wait state
// Notes: one pin model on channel 0
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module test_one_shot_timer_pwm;
  import pwm_pkg::*;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, pin_tristate = 1, hready, irq, pad;
  logic [5:0] haddr = '0;
  logic [1:0] htrans = 2'h0, mo;
  logic [31:0] hwdata = '0, hrdata, rd, c;
  int num_errors = 0, checks_done = 0;
  always #25 clk = ~clk;
  one_shot_timer_pwm one_shot_timer_pwm_i (.CLOCK(clk), .RESETN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .MOD_OUT(mo), .IRQ(irq));
  pin_model pin_model_i (.clk(clk), .src(mo[0]), .pin_tristate(pin_tristate), .pad(pad));
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge clk); while (!hready && ++n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hready && ++n < 50);
    rd = hrdata;
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic stopped();
    int n;
    n = 0;
    do xfer(1'b0, OFF_TIMER_CTRL, 32'h0); while (rd[0] && ++n < 40);
    `CHK(rd[0], 1'b0)
  endtask
  task automatic t_regs();
    xfer(1'b0, OFF_MOD_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b1, OFF_MOD_CTRL, 32'hff);
    xfer(1'b0, OFF_MOD_CTRL, 32'h0);
    `CHK(rd, 32'hb0)
    xfer(1'b1, OFF_MOD_CTRL, 32'h10);
    #1 `CHK(mo[0], 1'b0)
    xfer(1'b0, 6'h38, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_shot();
    xfer(1'b1, OFF_PERIOD, 32'h5);
    xfer(1'b1, OFF_DUTY, 32'h2);
    xfer(1'b1, OFF_MOD_CTRL, 32'h80);
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    xfer(1'b1, OFF_IRQ_STATUS, 32'h3);
    xfer(1'b1, OFF_TIMER_CTRL, 32'h41);
    #1 `CHK(mo[0], 1'b1)
    @(posedge clk);
    #1 `CHK(mo[0], 1'b1)
    @(posedge clk);
    #1 `CHK(mo[0], 1'b0)
    stopped();
    `CHK(irq, 1'b1)
    repeat (20) @(posedge clk);
    xfer(1'b0, OFF_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(mo[0], 1'b0)
    // driver enabled only after the flag, with the shot over and the output resting low
    pin_tristate <= 1'b0;
    @(posedge clk);
    #1 `CHK(pad, mo[0])
  endtask
  task automatic t_pause();
    xfer(1'b1, OFF_DUTY, 32'h4);
    xfer(1'b1, OFF_TIMER_CTRL, 32'h41);
    xfer(1'b1, OFF_TIMER_CTRL, 32'h40);
    repeat (12) @(posedge clk);
    #1 `CHK(mo[0], 1'b1)
    xfer(1'b0, OFF_COUNT, 32'h0);
    c = rd;
    repeat (5) @(posedge clk);
    xfer(1'b0, OFF_COUNT, 32'h0);
    `CHK(rd, c)
    xfer(1'b1, OFF_TIMER_CTRL, 32'h41);
    stopped();
    `CHK(mo[0], 1'b0)
  endtask
  task automatic t_src();
    xfer(1'b1, OFF_PERIOD + 6'h4, 32'h5);
    xfer(1'b1, OFF_DUTY + 6'h4, 32'h2);
    xfer(1'b1, OFF_CMP_CTRL + 6'h4, 32'h1);
    xfer(1'b1, OFF_MOD_CTRL + 6'h4, 32'h80);
    xfer(1'b1, OFF_TIMER_CTRL, 32'h41);
    #1 `CHK(mo, 2'b01)
    xfer(1'b1, OFF_TIMER_CTRL + 6'h4, 32'h41);
    #1 `CHK(mo[1], 1'b1)
  endtask
  task automatic t_fmt();
    // width from the high byte, timer ticking every second clock
    stopped();
    xfer(1'b1, OFF_CMP_CTRL, 32'h2);
    xfer(1'b1, OFF_DUTY, 32'h0301);
    xfer(1'b1, OFF_TIMER_CTRL, 32'h43);
    repeat (5) @(posedge clk);
    #1 `CHK(mo[0], 1'b1)
    @(posedge clk);
    #1 `CHK(mo[0], 1'b0)
    stopped();
    xfer(1'b1, OFF_CMP_CTRL, 32'h0);
  endtask
  task automatic t_cont();
    xfer(1'b1, OFF_TIMER_CTRL, 32'h01);
    repeat (30) @(posedge clk);
    xfer(1'b0, OFF_TIMER_CTRL, 32'h0);
    `CHK(rd[0], 1'b1)
    xfer(1'b1, OFF_TIMER_CTRL, 32'h0);
    xfer(1'b1, OFF_IRQ_MASK, 32'h0);
    #1 `CHK(irq, 1'b0)
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    #1 `CHK(irq, 1'b1)
    xfer(1'b1, OFF_IRQ_STATUS, 32'h1);
    #1 `CHK(irq, 1'b0)
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    hsel <= 1'b1;
    @(posedge clk);
    t_regs();
    t_shot();
    t_pause();
    t_src();
    t_fmt();
    t_cont();
    print_verdict();
  end
endmodule
`default_nettype wire
